// *** verilog/subtract_swap_xor_alu.sv ***
/*
  Execution slice: literal/register subtract, nibble swap, literal/register
  xor, with accumulator and status flags kept here.
  Assumes the core supplies the addressed file register value in the same
  cycle as the operation strobe, and performs the file write itself when
  file_we pulses. One operation per clock.
*/
`timescale 1ns/1ps

module subtract_swap_xor_alu
  import alu_slice_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic op_valid,
  input wire alu_op_e op,
  input wire logic [7:0] literal,
  input wire logic [6:0] file_addr,
  input wire logic [7:0] file_rdata,
  input wire logic dest_sel,
  output logic [7:0] acc,
  output logic carry_flag,
  output logic digit_carry_flag,
  output logic zero_flag,
  output logic file_we,
  output logic [6:0] file_waddr,
  output logic [7:0] file_wdata
);
  logic [7:0] acc_q, acc_d;
  logic c_q, c_d, dc_q, dc_d, z_q, z_d;
  logic we_q, we_d;
  logic [6:0] waddr_q, waddr_d;
  logic [7:0] wdata_q, wdata_d;
  logic [7:0] sub_min, sub_diff, result;
  logic sub_c, sub_dc, to_file;

  // ----------------------------------------
  // Shared subtractor
  // ----------------------------------------
  // One subtractor serves both forms; the minuend mux is cheaper than two
  assign sub_min = (op == OP_LIT_SUB) ? literal : file_rdata;

  sub_unit u_sub (
    .minuend(sub_min),
    .subtrahend(acc_q),
    .diff(sub_diff),
    .carry(sub_c),
    .digit_carry(sub_dc)
  );

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    acc_d = acc_q;
    c_d = c_q;
    dc_d = dc_q;
    z_d = z_q;
    we_d = 1'b0;
    waddr_d = waddr_q;
    wdata_d = wdata_q;
    result = 8'h00;
    to_file = 1'b0;
    if (op_valid) begin
      case (op)
        OP_LIT_SUB: begin
          result = sub_diff;
          {c_d, dc_d, z_d} = {sub_c, sub_dc, sub_diff == 8'h00};
        end
        OP_REG_SUB: begin
          result = sub_diff;
          to_file = (dest_sel == DEST_FILE);
          {c_d, dc_d, z_d} = {sub_c, sub_dc, sub_diff == 8'h00};
        end
        OP_SWAP: begin
          result = {file_rdata[NIB_LO +: NIB_W],
                    file_rdata[NIB_HI +: NIB_W]};
          to_file = (dest_sel == DEST_FILE);
        end
        OP_LIT_XOR: begin
          result = acc_q ^ literal;
          z_d = (result == 8'h00);
        end
        OP_REG_XOR: begin
          result = acc_q ^ file_rdata;
          to_file = (dest_sel == DEST_FILE);
          z_d = (result == 8'h00);
        end
        default: begin
          result = 8'h00;
        end
      endcase
      if (op != OP_NONE && (op == OP_LIT_SUB || op == OP_REG_SUB ||
          op == OP_SWAP || op == OP_LIT_XOR || op == OP_REG_XOR)) begin
        if (to_file) begin
          we_d = 1'b1;
          waddr_d = file_addr;
          wdata_d = result;
        end else begin
          acc_d = result;
        end
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      acc_q <= ACC_RESET;
      c_q <= FLAG_RESET;
      dc_q <= FLAG_RESET;
      z_q <= FLAG_RESET;
      we_q <= WE_RESET;
      waddr_q <= WADDR_RESET;
      wdata_q <= WDATA_RESET;
    end else begin
      acc_q <= acc_d;
      c_q <= c_d;
      dc_q <= dc_d;
      z_q <= z_d;
      we_q <= we_d;
      waddr_q <= waddr_d;
      wdata_q <= wdata_d;
    end
  end

  assign acc = acc_q;
  assign carry_flag = c_q;
  assign digit_carry_flag = dc_q;
  assign zero_flag = z_q;
  assign file_we = we_q;
  assign file_waddr = waddr_q;
  assign file_wdata = wdata_q;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  AST_LIT_SUB: assert property (@(posedge sys_clk) disable iff (rst)
    op_valid && op == OP_LIT_SUB |=>
      acc == 8'($past(literal) - $past(acc)))
    else $error("literal subtract result wrong");
  AST_REG_SUB: assert property (@(posedge sys_clk) disable iff (rst)
    op_valid && op == OP_REG_SUB && !dest_sel |=>
      acc == 8'($past(file_rdata) - $past(acc)))
    else $error("register subtract result wrong");
  AST_DEST_FILE: assert property (@(posedge sys_clk) disable iff (rst)
    op_valid && (op == OP_REG_SUB || op == OP_REG_XOR) && dest_sel |=>
      file_we && acc == $past(acc) && file_waddr == $past(file_addr))
    else $error("file destination not honoured");
  AST_SWAP_VAL: assert property (@(posedge sys_clk) disable iff (rst)
    op_valid && op == OP_SWAP && dest_sel |=>
      file_wdata == {$past(file_rdata[3:0]), $past(file_rdata[7:4])})
    else $error("swap value wrong");
  AST_SWAP_DEST: assert property (@(posedge sys_clk) disable iff (rst)
    op_valid && op == OP_SWAP && !dest_sel |=>
      !file_we && acc == {$past(file_rdata[3:0]), $past(file_rdata[7:4])})
    else $error("swap to accumulator wrong");
  AST_LIT_XOR: assert property (@(posedge sys_clk) disable iff (rst)
    op_valid && op == OP_LIT_XOR |=>
      acc == ($past(acc) ^ $past(literal)) && !file_we)
    else $error("literal xor wrong");
  AST_REG_XOR: assert property (@(posedge sys_clk) disable iff (rst)
    op_valid && op == OP_REG_XOR && !dest_sel |=>
      acc == ($past(acc) ^ $past(file_rdata)) && zero_flag == (acc == 8'h00))
    else $error("register xor wrong");
  AST_XOR_FLAGS: assert property (@(posedge sys_clk) disable iff (rst)
    op_valid && (op == OP_LIT_XOR || op == OP_REG_XOR) |=>
      $stable(carry_flag) && $stable(digit_carry_flag))
    else $error("xor touched carry flags");
  AST_SWAP_FLAGS: assert property (@(posedge sys_clk)
    disable iff (rst)
    op_valid && op == OP_SWAP |=>
      $stable(carry_flag) && $stable(digit_carry_flag) && $stable(zero_flag))
    else $error("swap touched flags");
  AST_SUB_CARRY: assert property (@(posedge sys_clk) disable iff (rst)
    op_valid && op == OP_LIT_SUB |=>
      carry_flag == ($past(literal) >= $past(acc)))
    else $error("subtract carry wrong");
  // Flags judged from operands, not from the shared subtractor's outputs
  AST_REG_SUB_FLAGS: assert property (@(posedge sys_clk)
    disable iff (rst)
    op_valid && op == OP_REG_SUB |=>
      carry_flag == ($past(file_rdata) >= $past(acc)) &&
      digit_carry_flag == ($past(file_rdata[3:0]) >= $past(acc[3:0])) &&
      zero_flag == ($past(file_rdata) == $past(acc)))
    else $error("register subtract flags wrong");
  AST_LIT_SUB_FLAGS: assert property (@(posedge sys_clk)
    disable iff (rst)
    op_valid && op == OP_LIT_SUB |=>
      digit_carry_flag == ($past(literal[3:0]) >= $past(acc[3:0])) &&
      zero_flag == (acc == 8'h00))
    else $error("literal subtract flags wrong");
  AST_REG_SUB_FILE: assert property (@(posedge sys_clk)
    disable iff (rst)
    op_valid && op == OP_REG_SUB && dest_sel |=>
      file_wdata == 8'($past(file_rdata) - $past(acc)))
    else $error("register subtract file data wrong");
  AST_REG_XOR_FILE: assert property (@(posedge sys_clk)
    disable iff (rst)
    op_valid && op == OP_REG_XOR && dest_sel |=>
      file_wdata == ($past(acc) ^ $past(file_rdata)))
    else $error("register xor file data wrong");
  AST_WE_SOURCE: assert property (@(posedge sys_clk)
    disable iff (rst)
    file_we |->
      $past(op_valid) && $past(dest_sel) && ($past(op) == OP_REG_SUB ||
      $past(op) == OP_SWAP || $past(op) == OP_REG_XOR))
    else $error("file write without a register op to file");

  // ----------------------------------------
  // Cover points
  // ----------------------------------------
  COV_SUB_ZERO: cover property (@(posedge sys_clk) disable iff (rst)
    op_valid && op == OP_LIT_SUB ##1 zero_flag);
  COV_SWAP_FILE: cover property (@(posedge sys_clk) disable iff (rst)
    op_valid && op == OP_SWAP && dest_sel ##1 file_we);
  COV_XOR_BACK: cover property (@(posedge sys_clk) disable iff (rst)
    op_valid && op == OP_REG_XOR ##1 op_valid && op == OP_LIT_XOR);
  COV_REG_SUB_FILE: cover property (@(posedge sys_clk) disable iff (rst)
    op_valid && op == OP_REG_SUB && dest_sel ##1 file_we);
  COV_SUB_BORROW: cover property (@(posedge sys_clk) disable iff (rst)
    op_valid && op == OP_LIT_SUB ##1 !carry_flag);
endmodule

// *** verilog/alu_slice_pkg.sv ***
/*
  Shared constants for the subtract/swap/xor datapath slice.
  Assumes a core that decodes instructions into one-hot operation strobes.
*/
package alu_slice_pkg;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 7;
  localparam logic [7:0] ACC_RESET = 8'h00;
  localparam logic FLAG_RESET = 1'b0;
  localparam logic WE_RESET = 1'b0;
  localparam logic [6:0] WADDR_RESET = 7'h00;
  localparam logic [7:0] WDATA_RESET = 8'h00;
  localparam logic DEST_ACC = 1'b0;
  localparam logic DEST_FILE = 1'b1;
  localparam int NIB_LO = 0;
  localparam int NIB_HI = 4;
  localparam int NIB_W = 4;

  // Operation codes, one-hot
  typedef enum logic [4:0] {
    OP_NONE = 5'h00,
    OP_LIT_SUB = 5'h01,
    OP_REG_SUB = 5'h02,
    OP_SWAP = 5'h04,
    OP_LIT_XOR = 5'h08,
    OP_REG_XOR = 5'h10
  } alu_op_e;
endpackage

// *** verilog/sub_unit.sv ***
/*
  Combinational subtractor: minuend minus subtrahend with borrow flags.
  Assumes operands are stable during the cycle in which they are used.
*/
`timescale 1ns/1ps
module sub_unit
  import alu_slice_pkg::*;
(
  input wire logic [7:0] minuend,
  input wire logic [7:0] subtrahend,
  output logic [7:0] diff,
  output logic carry,
  output logic digit_carry
);
  logic [8:0] full;
  logic [4:0] low;

  // ----------------------------------------
  // Two's complement add of inverted operand
  // ----------------------------------------
  always_comb begin
    full = {1'b0, minuend} + {1'b0, ~subtrahend} + 9'h001;
    low = {1'b0, minuend[3:0]} + {1'b0, ~subtrahend[3:0]} + 5'h01;
    diff = full[7:0];
    // Carry set means no borrow
    carry = full[8];
    digit_carry = low[4];
  end
endmodule

// *** bench/tb.sv ***
/*
  Self-checking bench for the subtract/swap/xor datapath slice.
  Assumes one-hot operation strobes and results one cycle after the strobe.
*/
`timescale 1ns/1ps
module tb
  import alu_slice_pkg::*;
;
  // ----------------------------------------
  // Stimulus and model state
  // ----------------------------------------
  logic sys_clk = 1'b0, rst = 1'b1, op_valid = 1'b0, dest_sel = 1'b0;
  alu_op_e op = OP_NONE;
  logic [7:0] literal = 8'h00, file_rdata = 8'h00;
  logic [6:0] file_addr = 7'h00;
  logic [7:0] acc, file_wdata;
  logic carry_flag, digit_carry_flag, zero_flag, file_we;
  logic [6:0] file_waddr;
  logic [7:0] m_acc = 8'h00, m_wd = 8'h00;
  logic [6:0] m_wa = 7'h00;
  logic m_c = 1'b0, m_dc = 1'b0, m_z = 1'b0;
  int n_fail = 0, num_checks = 0;

  always #2.5 sys_clk = ~sys_clk;

  subtract_swap_xor_alu subtract_swap_xor_alu_inst (.sys_clk(sys_clk),
    .rst(rst), .op_valid(op_valid), .op(op), .literal(literal),
    .file_addr(file_addr), .file_rdata(file_rdata), .dest_sel(dest_sel),
    .acc(acc), .carry_flag(carry_flag), .digit_carry_flag(digit_carry_flag),
    .zero_flag(zero_flag), .file_we(file_we), .file_waddr(file_waddr),
    .file_wdata(file_wdata));

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Called at a falling edge; returns one falling edge later, so ops chain
  task do_op(input alu_op_e o, input logic [7:0] k, input logic [6:0] a,
             input logic [7:0] f, input logic d);
    logic [7:0] b, r;
    logic wr;
    b = (o == OP_LIT_SUB || o == OP_LIT_XOR) ? k : f;
    r = m_acc;
    case (o)
      OP_LIT_SUB, OP_REG_SUB: begin
        r = b - m_acc;
        m_c = b >= m_acc;
        m_dc = b[3:0] >= m_acc[3:0];
        m_z = r == 8'h00;
      end
      OP_SWAP: r = {f[3:0], f[7:4]};
      OP_LIT_XOR, OP_REG_XOR: begin
        r = b ^ m_acc;
        m_z = r == 8'h00;
      end
      default: r = m_acc;
    endcase
    wr = d && (o == OP_REG_SUB || o == OP_SWAP || o == OP_REG_XOR);
    if (wr) begin
      m_wa = a;
      m_wd = r;
    end else begin
      m_acc = r;
    end
    op_valid = 1'b1;
    op = o;
    literal = k;
    file_addr = a;
    file_rdata = f;
    dest_sel = d;
    @(negedge sys_clk);
    chk("acc", acc, m_acc);
    chk("carry", carry_flag, m_c);
    chk("digit_carry", digit_carry_flag, m_dc);
    chk("zero", zero_flag, m_z);
    chk("file_we", file_we, wr);
    chk("file_waddr", file_waddr, m_wa);
    chk("file_wdata", file_wdata, m_wd);
  endtask

  task idle(input string nm);
    op_valid = 1'b0;
    op = OP_NONE;
    @(negedge sys_clk);
    chk("file_we_idle", file_we, 8'h00);
    $display("test %s finished", nm);
  endtask

  task complete_run;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task t_lit_sub;
    do_op(OP_LIT_SUB, 8'h05, 7'h00, 8'h00, 1'b1);
    do_op(OP_LIT_SUB, 8'h03, 7'h00, 8'h00, 1'b0);
    do_op(OP_LIT_SUB, 8'hFE, 7'h00, 8'h00, 1'b0);
    do_op(OP_LIT_SUB, 8'hFF, 7'h00, 8'h00, 1'b0);
    idle("lit_sub");
  endtask

  task t_reg_sub;
    do_op(OP_LIT_XOR, 8'hFC, 7'h00, 8'h00, 1'b0);
    do_op(OP_REG_SUB, 8'h00, 7'h7F, 8'h10, 1'b1);
    do_op(OP_REG_SUB, 8'h00, 7'h00, 8'h10, 1'b0);
    do_op(OP_REG_SUB, 8'h00, 7'h2A, 8'h0D, 1'b0);
    idle("reg_sub");
  endtask

  // Flags must survive the swap untouched
  task t_swap;
    do_op(OP_SWAP, 8'h00, 7'h11, 8'hA5, 1'b0);
    do_op(OP_SWAP, 8'h00, 7'h7F, 8'h3C, 1'b1);
    idle("swap");
  endtask

  task t_xor;
    do_op(OP_LIT_XOR, 8'hFF, 7'h00, 8'h00, 1'b1);
    do_op(OP_REG_XOR, 8'h00, 7'h55, 8'h0F, 1'b1);
    do_op(OP_REG_XOR, 8'h00, 7'h00, 8'hA5, 1'b0);
    do_op(OP_REG_XOR, 8'h00, 7'h7F, 8'h00, 1'b0);
    do_op(OP_LIT_XOR, 8'h00, 7'h00, 8'h00, 1'b0);
    idle("xor");
  endtask

  // Malformed codes are ignored entirely
  task t_refused;
    do_op(alu_op_e'(5'h03), 8'h12, 7'h01, 8'h34, 1'b1);
    do_op(OP_NONE, 8'h56, 7'h02, 8'h78, 1'b1);
    // A valid code without the strobe must not be taken
    op_valid = 1'b0;
    op = OP_LIT_SUB;
    literal = 8'h99;
    @(negedge sys_clk);
    chk("acc_no_strobe", acc, m_acc);
    chk("carry_no_strobe", carry_flag, m_c);
    idle("refused");
  endtask

  // Asynchronous reset mid-run clears everything, first op right after
  task t_reset;
    do_op(OP_REG_XOR, 8'h00, 7'h33, 8'h5A, 1'b1);
    op_valid = 1'b0;
    op = OP_NONE;
    rst = 1'b1;
    @(negedge sys_clk);
    chk("acc_rst", acc, ACC_RESET);
    chk("carry_rst", carry_flag, FLAG_RESET);
    chk("digit_carry_rst", digit_carry_flag, FLAG_RESET);
    chk("zero_rst", zero_flag, FLAG_RESET);
    chk("file_we_rst", file_we, WE_RESET);
    chk("file_waddr_rst", file_waddr, WADDR_RESET);
    chk("file_wdata_rst", file_wdata, WDATA_RESET);
    rst = 1'b0;
    m_acc = ACC_RESET;
    m_c = FLAG_RESET;
    m_dc = FLAG_RESET;
    m_z = FLAG_RESET;
    m_wa = WADDR_RESET;
    m_wd = WDATA_RESET;
    do_op(OP_LIT_SUB, 8'h01, 7'h00, 8'h00, 1'b0);
    idle("reset");
  endtask

  initial begin
    #4000;
    n_fail++;
    complete_run();
  end

  initial begin
    repeat (3) @(negedge sys_clk);
    rst = 1'b0;
    chk("acc_reset", acc, ACC_RESET);
    chk("zero_reset", zero_flag, FLAG_RESET);
    chk("carry_reset", carry_flag, FLAG_RESET);
    chk("digit_carry_reset", digit_carry_flag, FLAG_RESET);
    chk("file_we_reset", file_we, WE_RESET);
    t_lit_sub();
    t_reg_sub();
    t_swap();
    t_xor();
    t_reset();
    t_refused();
    complete_run();
  end
endmodule
